// ### bench/dss_drive_model.sv
`timescale 1ns/1ps
module dss_drive_model import dss_pkg::*; #(
   parameter int IDX = 500
) (
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic step_i,
   input  wire logic direction_i,
   output logic      track_zero_sense_n_o,
   output logic      index_o,
   output dss_id_t   id_o
);
   logic [7:0] pos = 8'h03;
   logic       step_q = 1'b0;
   int         ph = 0;
   // Head over track zero pulls the sense line low
   assign track_zero_sense_n_o = (pos != 8'h00);
   always @(posedge clk_i) begin
      step_q <= step_i;
      ph <= (rst_i || ph == IDX - 1) ? 0 : ph + 1;
      index_o <= (ph == 0);
      // One ID per revolution, sector 1, garbage when idle
      id_o <= (ph == IDX / 2) ? {1'b1, pos, 8'h01, 1'b1} : {1'b0, ~pos, 8'hfe, 1'b0};
      if (step_i && !step_q) begin
         pos <= direction_i ? pos + 8'h01 : pos - 8'h01;
      end
   end
endmodule

// ### bench/dss_seek_sector_test.sv
`timescale 1ns/1ps
module dss_seek_sector_test import dss_pkg::*;;
   localparam int IDX = 500;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        we = 1'b0;
   logic        cyc = 1'b0;
   logic        stb = 1'b0;
   logic [4:0]  adr = 5'h00;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat;
   logic [31:0] q;
   logic        ack, tz_n, idx, step, dir, spin, irq, breq, busy;
   dss_id_t     id;
   dss_byte_t   bytev = '0;
   dss_mark_t   markv = '0;
   int          fail_count = 0;
   int          num_checks = 0;
   int          cycles = 0;
   int          hi = 0;
   always #20 clk_i = ~clk_i;
   dss_seek_sector #(.SETTLE_CYCLES(100), .RATE00_CYCLES(200), .RATE01_CYCLES(300),
      .RATE10_CYCLES(120), .RATE11_CYCLES(150)) dut (
      .clk_i(clk_i), .rst_i(rst_i), .adr_i(adr), .dat_i(wdat), .dat_o(rdat), .we_i(we),
      .sel_i(4'h3), .cyc_i(cyc), .stb_i(stb), .ack_o(ack), .track_zero_sense_n_i(tz_n),
      .index_i(idx), .id_i(id), .byte_i(bytev), .mark_i(markv), .step_o(step), .direction_o(dir),
      .spindle_power_out_o(spin), .completion_interrupt_o(irq), .byte_request_o(breq),
      .busy_o(busy));
   dss_drive_model #(.IDX(IDX)) drive (.clk_i(clk_i), .rst_i(rst_i), .step_i(step),
      .direction_i(dir), .track_zero_sense_n_o(tz_n), .index_o(idx), .id_o(id));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= {24'h0, d};
      @(posedge clk_i);
      while (ack !== 1'b1) @(posedge clk_i);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic rd(input logic [4:0] a, input logic [31:0] exp);
      bus(1'b0, a, 8'h00);
      chk(q, exp);
   endtask
   task automatic run(input logic [7:0] c);
      bus(1'b1, ADR_CMD, c);
      while (irq !== 1'b1) @(posedge clk_i);
   endtask
   task automatic report_and_stop();
      $display("checks %0d errors %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // Step width watch and run limit
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 40000) begin
         fail_count++;
         report_and_stop();
      end
      if (step === 1'b1) begin
         hi++;
      end else if (hi != 0) begin
         chk(hi, 100);
         hi = 0;
      end
   end
   initial begin
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      chk({spin, irq, busy, step}, 4'h0);
      rd(ADR_CTRL, 32'h0000_0a00);
      rd(5'h18, 32'h0);
      bus(1'b1, ADR_CMD, 8'h03);
      chk({31'h0, spin}, 32'h1);
      while (irq !== 1'b1) @(posedge clk_i);
      rd(ADR_STATUS, 32'h80);
      rd(ADR_TRACK, 32'h0);
      run(8'h52);
      chk({31'h0, dir}, 32'h1);
      rd(ADR_TRACK, 32'h1);
      run(8'h30);
      rd(ADR_TRACK, 32'h2);
      run(8'h71);
      chk({31'h0, dir}, 32'h0);
      rd(ADR_TRACK, 32'h1);
      bus(1'b1, ADR_DATA, 8'h05);
      run(8'h16);
      rd(ADR_TRACK, 32'h5);
      rd(ADR_STATUS, 32'h80);
      bus(1'b1, ADR_SECTOR, 8'h09);
      bus(1'b1, ADR_CMD, 8'h80);
      chk({31'h0, busy}, 32'h1);
      while (irq !== 1'b1) @(posedge clk_i);
      rd(ADR_STATUS, 32'h90);
      bus(1'b1, ADR_SECTOR, 8'h01);
      bytev <= '{valid: 1'b1, data: 8'ha5};
      markv <= '{data_field_marker: 1'b1, deleted: 1'b1, tick: 1'b0, last: 1'b1, crc_ok: 1'b1};
      run(8'h80);
      bytev <= '0;
      markv <= '0;
      chk({31'h0, breq}, 32'h1);
      rd(ADR_STATUS, 32'ha2);
      rd(ADR_DATA, 32'ha5);
      chk({31'h0, breq}, 32'h0);
      repeat (10 * IDX) @(posedge clk_i);
      chk({31'h0, spin}, 32'h0);
      report_and_stop();
   end
endmodule

// ### verilog/dss_pkg.sv
package dss_pkg;
   // Core clock
   localparam int CLK_MHZ         = 25;
   // Drive timing in printed units
   localparam int PULSE_MFM_US    = 4;
   localparam int PULSE_FM_US     = 8;
   localparam int DIR_SETUP_US    = 24;
   localparam int SETTLE_MS       = 15;
   localparam int RATE00_MS       = 6;
   localparam int RATE01_MS       = 12;
   localparam int RATE10_MS       = 2;
   localparam int RATE11_MS       = 3;
   // Derived cycle counts
   localparam int PULSE_MFM_CYC   = PULSE_MFM_US * CLK_MHZ;
   localparam int PULSE_FM_CYC    = PULSE_FM_US * CLK_MHZ;
   localparam int DIR_SETUP_CYC   = DIR_SETUP_US * CLK_MHZ;
   localparam int SETTLE_CYC      = SETTLE_MS * 1000 * CLK_MHZ;
   localparam int RATE00_CYC      = RATE00_MS * 1000 * CLK_MHZ;
   localparam int RATE01_CYC      = RATE01_MS * 1000 * CLK_MHZ;
   localparam int RATE10_CYC      = RATE10_MS * 1000 * CLK_MHZ;
   localparam int RATE11_CYC      = RATE11_MS * 1000 * CLK_MHZ;
   localparam int TIMER_W         = 20;
   // Revolution, step and byte limits
   localparam logic [7:0] SPINUP_INDEX = 8'h06;
   localparam logic [7:0] IDLE_REVS    = 8'h09;
   localparam logic [7:0] SEARCH_REVS  = 8'h05;
   localparam logic [7:0] RESTORE_MAX  = 8'hff;
   localparam logic [7:0] DAM_FM_BYTES = 8'h1e;
   localparam logic [7:0] DAM_MFM_BYTES = 8'h2b;
   // Register byte addresses
   localparam logic [4:0] ADR_CMD     = 5'h00;
   localparam logic [4:0] ADR_STATUS  = 5'h04;
   localparam logic [4:0] ADR_TRACK   = 5'h08;
   localparam logic [4:0] ADR_SECTOR  = 5'h0c;
   localparam logic [4:0] ADR_DATA    = 5'h10;
   localparam logic [4:0] ADR_CTRL    = 5'h14;
   // Status bit positions
   localparam int ST_BUSY  = 0;
   localparam int ST_BREQ  = 1;
   localparam int ST_LOST  = 2;
   localparam int ST_CRC   = 3;
   localparam int ST_RNF   = 4;
   localparam int ST_DDM   = 5;
   localparam int ST_MOTOR = 7;
   // Command fields
   localparam int F_UPD    = 4;
   localparam int F_NOSPIN = 3;
   localparam int F_VER    = 2;
   // Opcodes in command bits 7..4, the 3-bit ones in bits 7..5
   localparam logic [3:0] OP_RESTORE = 4'h0;
   localparam logic [3:0] OP_SEEK    = 4'h1;
   localparam logic [3:0] OP_FORCE   = 4'hd;
   localparam logic [2:0] OP_STEP    = 3'h1;
   localparam logic [2:0] OP_STEPIN  = 3'h2;
   localparam logic [2:0] OP_STEPOUT = 3'h3;
   localparam logic [2:0] OP_READ    = 3'h4;
   // Reset values
   localparam logic [7:0] SPT_RST = 8'h0a;

   typedef struct packed {
      logic       valid;
      logic [7:0] track;
      logic [7:0] sector;
      logic       crc_ok;
   } dss_id_t;

   typedef struct packed {
      logic       valid;
      logic [7:0] data;
   } dss_byte_t;

   typedef struct packed {
      logic data_field_marker;
      logic deleted;
      logic tick;
      logic last;
      logic crc_ok;
   } dss_mark_t;
endpackage

// ### verilog/dss_seek_sector.sv
// Register access over Wishbone and the register offsets were left to the implementer.
`timescale 1ns/1ps
// Summary of operation
// - Step pulse 4 us MFM, 8 us FM
// - Direction high inward, settled 24 us before
// - 15 ms settle before verify, or when E flag set
// - Verify track match, good CRC ends cleanly
// - Verify match, bad CRC flags, keeps looking
// - Verify fails after 5 revolutions: seek error
// - Spin-up: motor on, wait 6 index pulses
// - Motor off after 9 idle revolutions
// - Restore steps out until track zero, clears track
// - Restore gives up after 255 steps
// - Seek steps until track equals target
// - Step repeats last direction, optional update
// - Step-in increments track when update set
// - Step-out decrements track when update set
// - Sector command sets busy, optional settle
// - Match track then sector, need good CRC
// - Record not found after 5 revolutions
// - Multiple sectors increment until past last
// - Data mark within 30/43 bytes or re-search
// - Bytes to holding register, overrun sets lost
// - Data CRC error flags and terminates
// - Status bit 5 records deleted data mark
// - Step rate code selects 6/12/2/3 ms
// - Positioning bits: update, no-spin, verify
// - Sector bits: multi, no-spin, settle delay
module dss_seek_sector import dss_pkg::*; #(
   parameter int SETTLE_CYCLES = SETTLE_CYC,
   parameter int RATE00_CYCLES = RATE00_CYC,
   parameter int RATE01_CYCLES = RATE01_CYC,
   parameter int RATE10_CYCLES = RATE10_CYC,
   parameter int RATE11_CYCLES = RATE11_CYC
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic [4:0]  adr_i,
   input  wire logic [31:0] dat_i,
   output logic      [31:0] dat_o,
   input  wire logic        we_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   output logic             ack_o,
   input  wire logic        track_zero_sense_n_i,
   input  wire logic        index_i,
   input  wire dss_id_t     id_i,
   input  wire dss_byte_t   byte_i,
   input  wire dss_mark_t   mark_i,
   output logic             step_o,
   output logic             direction_o,
   output logic             spindle_power_out_o,
   output logic             completion_interrupt_o,
   output logic             byte_request_o,
   output logic             busy_o
);
   if (SETTLE_CYCLES < 1 || SETTLE_CYCLES >= 2**TIMER_W || RATE00_CYCLES < 1 || RATE00_CYCLES >= 2**TIMER_W ||
       RATE01_CYCLES < 1 || RATE01_CYCLES >= 2**TIMER_W || RATE10_CYCLES < 1 || RATE10_CYCLES >= 2**TIMER_W ||
       RATE11_CYCLES < 1 || RATE11_CYCLES >= 2**TIMER_W) begin : g_chk
      $error("dss_seek_sector: delay count outside timer range");
   end

   typedef enum logic [3:0] {
      S_IDLE, S_SPIN, S_START, S_DSET, S_PULSE, S_RATE, S_SETTLE,
      S_VERIFY, S_SEARCH, S_DAM, S_READ, S_DONE
   } dss_state_t;

   dss_state_t         state;
   logic [7:0]         cmd;
   logic [7:0]         track;
   logic [7:0]         sector;
   logic [7:0]         byte_holding_register;
   logic               fm;
   logic [7:0]         spt;
   logic               st_lost;
   logic               st_crc;
   logic               st_rnf;
   logic               st_ddm;
   logic [7:0]         steps;
   logic [7:0]         revs;
   logic [7:0]         bytes;
   logic [TIMER_W-1:0] timer;

   // Bus decode
   wire        wb_take  = cyc_i & stb_i & ~ack_o;
   wire        wr       = wb_take & we_i;
   wire        rd       = wb_take & ~we_i;
   wire        wr_cmd   = wr & (adr_i == ADR_CMD) & sel_i[0];
   wire        wr_trk   = wr & (adr_i == ADR_TRACK) & sel_i[0];
   wire        wr_sec   = wr & (adr_i == ADR_SECTOR) & sel_i[0];
   wire        wr_dat   = wr & (adr_i == ADR_DATA) & sel_i[0];
   wire        wr_ctl   = wr & (adr_i == ADR_CTRL);
   wire        rd_stat  = rd & (adr_i == ADR_STATUS);
   wire        rd_dat   = rd & (adr_i == ADR_DATA);
   wire        force_it = wr_cmd & (dat_i[7:4] == OP_FORCE);
   wire        accept   = wr_cmd & ~force_it & ~busy_o;
   wire [7:0]  status   = {spindle_power_out_o, 1'b0, st_ddm, st_rnf, st_crc, st_lost, byte_request_o, busy_o};
   wire [31:0] rd_word  = (adr_i == ADR_CMD)    ? {24'h0, cmd} :
                          (adr_i == ADR_STATUS) ? {24'h0, status} :
                          (adr_i == ADR_TRACK)  ? {24'h0, track} :
                          (adr_i == ADR_SECTOR) ? {24'h0, sector} :
                          (adr_i == ADR_DATA)   ? {24'h0, byte_holding_register} :
                          (adr_i == ADR_CTRL)   ? {16'h0, spt, 7'h0, fm} : 32'h0;

   // Command decode
   wire is_t1      = ~cmd[7];
   wire is_restore = cmd[7:4] == OP_RESTORE;
   wire is_seek    = cmd[7:4] == OP_SEEK;
   wire is_stepin  = cmd[7:5] == OP_STEPIN;
   wire is_stepout = cmd[7:5] == OP_STEPOUT;
   wire is_step    = cmd[7:5] == OP_STEP;
   wire is_read    = cmd[7:5] == OP_READ;
   wire upd        = cmd[F_UPD] & ~is_restore & ~is_seek;
   wire verify     = cmd[F_VER];
   wire multi      = cmd[F_UPD];
   wire tz         = ~track_zero_sense_n_i;

   // Timing selection
   wire [TIMER_W-1:0] rate_ld  = (cmd[1:0] == 2'h0) ? TIMER_W'(RATE00_CYCLES - 1) :
                                 (cmd[1:0] == 2'h1) ? TIMER_W'(RATE01_CYCLES - 1) :
                                 (cmd[1:0] == 2'h2) ? TIMER_W'(RATE10_CYCLES - 1) :
                                                      TIMER_W'(RATE11_CYCLES - 1);
   wire [TIMER_W-1:0] pulse_ld = fm ? TIMER_W'(PULSE_FM_CYC - 1) : TIMER_W'(PULSE_MFM_CYC - 1);
   wire [TIMER_W-1:0] settl_ld = TIMER_W'(SETTLE_CYCLES - 1);
   wire [TIMER_W-1:0] dset_ld  = TIMER_W'(DIR_SETUP_CYC - 1);
   wire [7:0]         dam_lim  = fm ? DAM_FM_BYTES : DAM_MFM_BYTES;
   wire               t_done   = timer == '0;
   wire               rev_end  = index_i & (revs == SEARCH_REVS - 8'h01);
   wire               trk_hit  = id_i.valid & (id_i.track == track);
   wire               sec_hit  = trk_hit & (id_i.sector == sector);
   wire               at_tgt   = track == byte_holding_register;
   wire               lost_now = byte_i.valid & byte_request_o & ~rd_dat;
   wire [7:0]         trk_step = direction_o ? track + 8'h01 : track - 8'h01;

   assign busy_o = state != S_IDLE;
   assign step_o = state == S_PULSE;

   // Wishbone slave: one wait state, unmapped reads return zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         dat_o <= 32'h0;
      end else begin
         ack_o <= wb_take;
         if (rd) begin
            dat_o <= rd_word;
         end
      end
   end

   // Interrupt and byte request: hardware set beats software clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         completion_interrupt_o <= 1'b0;
         byte_request_o         <= 1'b0;
      end else begin
         if (rd_stat || accept) begin
            completion_interrupt_o <= 1'b0;
         end
         if (force_it && dat_i[3]) begin
            completion_interrupt_o <= 1'b1;
         end
         if (state == S_DONE) begin
            completion_interrupt_o <= 1'b1;
         end
         if (rd_dat || accept) begin
            byte_request_o <= 1'b0;
         end
         if (state == S_READ && byte_i.valid) begin
            byte_request_o <= 1'b1;
         end
      end
   end

   // Host configuration registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fm  <= 1'b0;
         spt <= SPT_RST;
      end else if (wr_ctl) begin
         if (sel_i[0]) begin
            fm <= dat_i[0];
         end
         if (sel_i[1]) begin
            spt <= dat_i[15:8];
         end
      end
   end

   // Command sequencer
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state                 <= S_IDLE;
         cmd                   <= 8'h0;
         track                 <= 8'h0;
         sector                <= 8'h0;
         byte_holding_register <= 8'h0;
         st_lost               <= 1'b0;
         st_crc                <= 1'b0;
         st_rnf                <= 1'b0;
         st_ddm                <= 1'b0;
         steps                 <= 8'h0;
         revs                  <= 8'h0;
         bytes                 <= 8'h0;
         timer                 <= '0;
         direction_o           <= 1'b0;
         spindle_power_out_o   <= 1'b0;
      end else begin
         timer <= t_done ? timer : timer - TIMER_W'(1);
         if (wr_trk) track <= dat_i[7:0];
         if (wr_sec) sector <= dat_i[7:0];
         if (wr_dat) byte_holding_register <= dat_i[7:0];
         if (index_i) revs <= revs + 8'h01;
         case (state)
            S_IDLE: begin
               if (spindle_power_out_o && index_i && revs == IDLE_REVS - 8'h01) begin
                  spindle_power_out_o <= 1'b0;
               end
               if (accept) begin
                  cmd     <= dat_i[7:0];
                  st_lost <= 1'b0;
                  st_crc  <= 1'b0;
                  st_rnf  <= 1'b0;
                  st_ddm  <= 1'b0;
                  steps   <= 8'h0;
                  revs    <= 8'h0;
                  if (!dat_i[F_NOSPIN] && !spindle_power_out_o) begin
                     spindle_power_out_o <= 1'b1;
                     state               <= S_SPIN;
                  end else begin
                     state <= S_START;
                  end
               end
            end
            S_SPIN: begin
               if (index_i && revs == SPINUP_INDEX - 8'h01) begin
                  state <= S_START;
               end
            end
            S_START: begin
               timer <= dset_ld;
               state <= S_DSET;
               if (is_read) begin
                  revs  <= 8'h0;
                  timer <= settl_ld;
                  state <= verify ? S_SETTLE : S_SEARCH;
               end else if (!is_t1) begin
                  state <= S_DONE;
               end else if (is_restore) begin
                  direction_o <= 1'b0;
                  if (tz) begin
                     track <= 8'h0;
                     revs  <= 8'h0;
                     timer <= settl_ld;
                     state <= verify ? S_SETTLE : S_DONE;
                  end
               end else if (is_seek) begin
                  direction_o <= byte_holding_register > track;
                  if (at_tgt) begin
                     revs  <= 8'h0;
                     timer <= settl_ld;
                     state <= verify ? S_SETTLE : S_DONE;
                  end
               end else if (is_stepin) begin
                  direction_o <= 1'b1;
               end else if (is_stepout) begin
                  direction_o <= 1'b0;
               end
            end
            S_DSET: begin
               if (t_done) begin
                  timer <= pulse_ld;
                  state <= S_PULSE;
                  steps <= steps + 8'h01;
                  if (is_seek || upd) track <= trk_step;
               end
            end
            S_PULSE: begin
               if (t_done) begin
                  timer <= rate_ld;
                  state <= S_RATE;
               end
            end
            S_RATE: begin
               if (t_done) begin
                  revs  <= 8'h0;
                  timer <= settl_ld;
                  state <= verify ? S_SETTLE : S_DONE;
                  if (is_restore && tz) begin
                     track <= 8'h0;
                  end else if (is_restore && steps == RESTORE_MAX) begin
                     st_rnf <= verify;
                  end else if (is_restore || (is_seek && !at_tgt)) begin
                     timer <= pulse_ld;
                     state <= S_PULSE;
                     steps <= steps + 8'h01;
                     if (is_seek) track <= trk_step;
                  end
               end
            end
            S_SETTLE: begin
               if (t_done) begin
                  revs  <= 8'h0;
                  state <= is_t1 ? S_VERIFY : S_SEARCH;
               end
            end
            S_VERIFY: begin
               if (trk_hit && id_i.crc_ok) begin
                  state <= S_DONE;
               end else begin
                  if (trk_hit) st_crc <= 1'b1;
                  if (rev_end) begin
                     st_rnf <= 1'b1;
                     state  <= S_DONE;
                  end
               end
            end
            S_SEARCH, S_DAM: begin
               if (state == S_SEARCH && sec_hit && id_i.crc_ok) begin
                  bytes <= 8'h0;
                  state <= S_DAM;
               end else if (rev_end) begin
                  st_rnf <= 1'b1;
                  state  <= S_DONE;
               end else if (state == S_DAM && mark_i.data_field_marker) begin
                  st_ddm <= mark_i.deleted;
                  state  <= S_READ;
               end else if (state == S_DAM && mark_i.tick) begin
                  bytes <= bytes + 8'h01;
                  if (bytes == dam_lim - 8'h01) state <= S_SEARCH;
               end
            end
            S_READ: begin
               if (byte_i.valid && !lost_now) byte_holding_register <= byte_i.data;
               if (lost_now) st_lost <= 1'b1;
               if (mark_i.last) begin
                  revs <= 8'h0;
                  if (!mark_i.crc_ok) begin
                     st_crc <= 1'b1;
                     state  <= S_DONE;
                  end else if (multi) begin
                     sector <= sector + 8'h01;
                     state  <= (sector < spt) ? S_SEARCH : S_DONE;
                  end else begin
                     state <= S_DONE;
                  end
               end
            end
            S_DONE: begin
               revs  <= 8'h0;
               state <= S_IDLE;
            end
            default: begin
               state <= S_IDLE;
            end
         endcase
         if (force_it) begin
            state <= S_IDLE;
         end
      end
   end

   // Checking helpers
   logic [7:0] hi_cnt;
   logic [9:0] dir_age;
   logic       dir_q;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         hi_cnt  <= 8'h0;
         dir_age <= 10'h0;
         dir_q   <= 1'b0;
      end else begin
         hi_cnt  <= step_o ? hi_cnt + 8'h01 : 8'h0;
         dir_q   <= direction_o;
         dir_age <= (direction_o != dir_q) ? 10'h0 : (&dir_age ? dir_age : dir_age + 10'h001);
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   step_width_a: assert property (
      $fell(step_o) |-> $past(hi_cnt) == (fm ? 8'(PULSE_FM_CYC - 1) : 8'(PULSE_MFM_CYC - 1)))
      else $error("step pulse width wrong");
   dir_setup_a: assert property (
      $rose(step_o) |-> dir_age >= 10'(DIR_SETUP_CYC - 1))
      else $error("direction not settled before step");
   spin_start_a: assert property (
      accept && !dat_i[F_NOSPIN] && !spindle_power_out_o |=> state == S_SPIN && spindle_power_out_o)
      else $error("spin-up not started");
   motor_off_a: assert property (
      state == S_IDLE && !accept && spindle_power_out_o && index_i && revs == IDLE_REVS - 8'h01
      |=> !spindle_power_out_o)
      else $error("motor not switched off after idle revolutions");
   verify_ok_a: assert property (
      state == S_VERIFY && trk_hit && id_i.crc_ok && !force_it |=> state == S_DONE ##1 completion_interrupt_o)
      else $error("verify match did not complete");
   verify_crc_a: assert property (
      state == S_VERIFY && trk_hit && !id_i.crc_ok && !rev_end && !force_it |=> st_crc && state == S_VERIFY)
      else $error("verify crc error not flagged");
   search_rnf_a: assert property (
      state == S_SEARCH && rev_end && !(sec_hit && id_i.crc_ok) && !force_it |=> st_rnf ##1 !busy_o)
      else $error("record not found not reported");
   lost_byte_a: assert property (
      state == S_READ && lost_now |=> st_lost && byte_holding_register == $past(byte_holding_register))
      else $error("overrun not flagged");
   restore_zero_a: assert property (
      state == S_RATE && t_done && is_restore && tz && !force_it |=> track == 8'h0 && !step_o)
      else $error("restore did not clear track");
endmodule
